// file: bsp_consts.svh
// Constants for the burst-of-two port link
`ifndef BSP_CONSTS_SVH
`define BSP_CONSTS_SVH
`define BSP_ADDR_W 19
`define BSP_WORD_W 18
`define BSP_LANE_W 9
`define BSP_LANES 2
`define BSP_DEPTH 524288
`define BSP_SYNC_W 45
`define BSP_STRAP_WAIT 2'h3
`define BSP_CAL_LAST 10'h3FF
`define BSP_PH_RESET 3'h7
`define BSP_ISSUE_PH 3'h5
`define BSP_HALF2_PH 3'h1
`define BSP_SAMPLE0 5'h11
`define BSP_SAMPLE1 5'h15
`endif

// file: bsp_ctrl_end.sv
// Memory controller end: makes the link clocks and drives requests
`timescale 1ns/10ps
`include "bsp_consts.svh"
module bsp_ctrl_end
  import bsp_pkg::*;
#(
  parameter bit SINGLE_CLOCK = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  bsp_link_if.ctrl link,
  input wire logic rd_req_i,
  input wire bsp_addr_t rd_addr_i,
  output logic rd_ack_o,
  input wire logic wr_req_i,
  input wire bsp_addr_t wr_addr_i,
  input wire logic [2*`BSP_WORD_W-1:0] wr_data_i,
  input wire logic [2*`BSP_LANES-1:0] wr_bws_n_i,
  output logic wr_ack_o,
  output logic rd_valid_o,
  output logic [2*`BSP_WORD_W-1:0] rd_data_o,
  input wire logic rd_ready_i
);
  logic [2:0] ph;
  logic [2:0] next_ph;
  bsp_addr_t wr_addr_q;
  bsp_word_t wr_hi_q;
  bsp_bws_t wr_bws_hi_q;
  bsp_word_t q_s1;
  bsp_word_t q_s2;
  bsp_word_t lo_q;
  logic [4:0] rd_timer;
  bsp_rd_e rd_st;
  logic rd_go;
  logic buf_ready;
  logic buf_push;

  // ****************************************
  // Link clock divider
  // ****************************************
  assign next_ph = ph + 3'h1;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ph <= `BSP_PH_RESET;
      link.in_clk <= 1'b0;
      link.in_clk_n <= 1'b1;
      link.out_clk <= SINGLE_CLOCK;
      link.out_clk_n <= 1'b1;
    end else begin
      ph <= next_ph;
      link.in_clk <= ~next_ph[2];
      link.in_clk_n <= next_ph[2];
      link.out_clk <= SINGLE_CLOCK | ~next_ph[2];
      link.out_clk_n <= SINGLE_CLOCK | next_ph[2];
    end
  end

  // ****************************************
  // Request launch
  // ****************************************
  assign rd_go = rd_req_i & (rd_st == BSP_RD_IDLE) & buf_ready;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      link.read_port_select_n <= 1'b1;
      link.write_port_select_n <= 1'b1;
      link.addr <= '0;
      link.wr_data <= '0;
      link.byte_write_select_n <= '1;
      wr_addr_q <= '0;
      wr_hi_q <= '0;
      wr_bws_hi_q <= '1;
      rd_ack_o <= 1'b0;
      wr_ack_o <= 1'b0;
    end else if (ph == `BSP_ISSUE_PH) begin
      link.read_port_select_n <= ~rd_go;
      link.write_port_select_n <= ~wr_req_i;
      link.addr <= rd_addr_i;
      link.wr_data <= wr_data_i[`BSP_WORD_W-1:0];
      link.byte_write_select_n <= wr_bws_n_i[`BSP_LANES-1:0];
      wr_addr_q <= wr_addr_i;
      wr_hi_q <= wr_data_i[2*`BSP_WORD_W-1:`BSP_WORD_W];
      wr_bws_hi_q <= wr_bws_n_i[2*`BSP_LANES-1:`BSP_LANES];
      rd_ack_o <= rd_go;
      wr_ack_o <= wr_req_i;
    end else if (ph == `BSP_HALF2_PH) begin
      link.read_port_select_n <= 1'b1;
      link.write_port_select_n <= 1'b1;
      link.addr <= wr_addr_q;
      link.wr_data <= wr_hi_q;
      link.byte_write_select_n <= wr_bws_hi_q;
      rd_ack_o <= 1'b0;
      wr_ack_o <= 1'b0;
    end else begin
      rd_ack_o <= 1'b0;
      wr_ack_o <= 1'b0;
    end
  end

  // ****************************************
  // Read return capture
  // ****************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_s1 <= '0;
      q_s2 <= '0;
    end else begin
      q_s1 <= link.rd_data;
      q_s2 <= q_s1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_st <= BSP_RD_IDLE;
      rd_timer <= 5'h0;
      lo_q <= '0;
    end else begin
      case (rd_st)
        BSP_RD_IDLE: begin
          if (ph == `BSP_ISSUE_PH && rd_go) begin
            rd_st <= BSP_RD_WAIT;
            rd_timer <= 5'h1;
          end
        end
        BSP_RD_WAIT: begin
          rd_timer <= rd_timer + 5'h1;
          if (rd_timer == `BSP_SAMPLE0) begin
            lo_q <= q_s2;
          end
          if (rd_timer == `BSP_SAMPLE1) begin
            rd_st <= BSP_RD_IDLE;
          end
        end
        default: begin
          rd_st <= BSP_RD_IDLE;
        end
      endcase
    end
  end

  assign buf_push = (rd_st == BSP_RD_WAIT) && (rd_timer == `BSP_SAMPLE1);

  bsp_pair_buf u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(buf_push),
    .in_data_i({q_s2, lo_q}),
    .in_ready_o(buf_ready),
    .out_valid_o(rd_valid_o),
    .out_data_o(rd_data_o),
    .out_ready_i(rd_ready_i)
  );
endmodule

// file: bsp_dev_end.sv
// Memory device end: burst-of-two read and write ports with the array
`timescale 1ns/10ps
`include "bsp_consts.svh"
// Overview of operation
// - Read starts on read select low at K rise
// - Low word on C rise, high on C-bar
// - Outputs float after next C rise when idle
// - Write select low latches first data word
// - K-bar rise latches address, word two, commits
// - Deselected write port ignores inputs after pending
// - Byte selects accompany each data word
// - Two 512K x 18 arrays, bursts of two
// - Controls and data registered on input clocks
// - Read data launched on output clock pair
// - Single-clock mode equals zero-skew dual clocks
// - Both output clocks high selects single-clock
// - Read and write ports work concurrently
// - Same-location read returns most recent data
// - Port selects sampled only at K rise
// - Pending transactions finish before deselect
// - Impedance recalibrated every 1024 cycles
// - Power up deselected, outputs floating
// - Each byte select governs one 9-bit lane
// - Read at t delivers both words in t+1
module bsp_dev_end
  import bsp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  bsp_link_if.device link,
  output logic single_clock_o,
  output logic impedance_cal_o
);
  logic [`BSP_SYNC_W-1:0] pin_s1;
  logic [`BSP_SYNC_W-1:0] pin_s2;
  logic [3:0] clk_prev;
  logic k_s;
  logic kn_s;
  logic c_s;
  logic cn_s;
  logic rsel_n_s;
  logic wsel_n_s;
  bsp_addr_t addr_s;
  bsp_word_t data_s;
  bsp_bws_t bws_s;
  logic k_rise;
  logic kn_rise;
  logic c_rise;
  logic cn_rise;
  logic out_rise;
  logic out_fall;
  logic [1:0] strap_cnt;
  logic strap_done;
  logic rd_live;
  bsp_addr_t rd_addr;
  bsp_addr_t q_addr;
  logic second_pend;
  logic wr_live;
  bsp_word_t wd0;
  bsp_bws_t wb0;
  logic commit;
  bsp_word_t lo_rd;
  bsp_word_t hi_rd;
  logic [9:0] cal_cnt;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      clk_prev <= 4'h0;
    end else begin
      pin_s1 <= {link.in_clk, link.in_clk_n, link.out_clk, link.out_clk_n,
                 link.read_port_select_n, link.write_port_select_n,
                 link.addr, link.wr_data, link.byte_write_select_n};
      pin_s2 <= pin_s1;
      clk_prev <= pin_s2[`BSP_SYNC_W-1:`BSP_SYNC_W-4];
    end
  end

  assign {k_s, kn_s, c_s, cn_s, rsel_n_s, wsel_n_s, addr_s, data_s, bws_s} = pin_s2;

  // ****************************************
  // Clock edge detection
  // ****************************************
  assign k_rise = k_s & ~clk_prev[3];
  assign kn_rise = kn_s & ~clk_prev[2];
  assign c_rise = c_s & ~clk_prev[1];
  assign cn_rise = cn_s & ~clk_prev[0];
  assign out_rise = single_clock_o ? k_rise : c_rise;
  assign out_fall = single_clock_o ? kn_rise : cn_rise;

  // ****************************************
  // Clock mode strap
  // ****************************************
  assign strap_done = (strap_cnt == `BSP_STRAP_WAIT);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_cnt <= 2'h0;
      single_clock_o <= 1'b0;
    end else if (!strap_done) begin
      strap_cnt <= strap_cnt + 2'h1;
      single_clock_o <= c_s & cn_s;
    end
  end

  // ****************************************
  // Read port capture
  // ****************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_live <= 1'b0;
      rd_addr <= '0;
    end else if (k_rise && strap_done) begin
      rd_live <= ~rsel_n_s;
      if (!rsel_n_s) begin
        rd_addr <= addr_s;
      end
    end
  end

  // ****************************************
  // Read output registers
  // ****************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      link.rd_data <= '0;
      link.rd_data_oe <= 1'b0;
      q_addr <= '0;
      second_pend <= 1'b0;
    end else if (out_rise) begin
      if (rd_live) begin
        link.rd_data <= lo_rd;
        link.rd_data_oe <= 1'b1;
        q_addr <= rd_addr;
        second_pend <= 1'b1;
      end else begin
        link.rd_data_oe <= 1'b0;
        second_pend <= 1'b0;
      end
    end else if (out_fall && second_pend) begin
      link.rd_data <= hi_rd;
      second_pend <= 1'b0;
    end
  end

  // ****************************************
  // Write port capture
  // ****************************************
  assign commit = kn_rise & wr_live;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_live <= 1'b0;
      wd0 <= '0;
      wb0 <= '1;
    end else if (k_rise && strap_done) begin
      wr_live <= ~wsel_n_s;
      if (!wsel_n_s) begin
        wd0 <= data_s;
        wb0 <= bws_s;
      end
    end else if (kn_rise) begin
      wr_live <= 1'b0;
    end
  end

  // ****************************************
  // Storage arrays, a low-word and a high-word array per byte lane
  // ****************************************
  for (genvar i = 0; i < `BSP_LANES; i++) begin : g_lane
    logic [`BSP_LANE_W-1:0] lo_mem [0:`BSP_DEPTH-1];
    logic [`BSP_LANE_W-1:0] hi_mem [0:`BSP_DEPTH-1];

    always_ff @(posedge clk_i) begin
      if (commit && !wb0[i]) begin
        lo_mem[addr_s] <= wd0[i*`BSP_LANE_W +: `BSP_LANE_W];
      end
      if (commit && !bws_s[i]) begin
        hi_mem[addr_s] <= data_s[i*`BSP_LANE_W +: `BSP_LANE_W];
      end
    end

    assign lo_rd[i*`BSP_LANE_W +: `BSP_LANE_W] = lo_mem[rd_addr];
    assign hi_rd[i*`BSP_LANE_W +: `BSP_LANE_W] = hi_mem[q_addr];
  end

  // ****************************************
  // Impedance recalibration tick
  // ****************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cal_cnt <= 10'h0;
      impedance_cal_o <= 1'b0;
    end else begin
      impedance_cal_o <= k_rise & (cal_cnt == `BSP_CAL_LAST);
      if (k_rise) begin
        cal_cnt <= cal_cnt + 10'h1;
      end
    end
  end
endmodule

// file: bsp_link_if.sv
// Link wires between the memory controller and the memory device
`timescale 1ns/10ps
`include "bsp_consts.svh"
interface bsp_link_if;
  import bsp_pkg::*;
  logic in_clk;
  logic in_clk_n;
  logic out_clk;
  logic out_clk_n;
  logic read_port_select_n;
  logic write_port_select_n;
  bsp_addr_t addr;
  bsp_word_t wr_data;
  bsp_bws_t byte_write_select_n;
  bsp_word_t rd_data;
  logic rd_data_oe;
  modport device (
    input in_clk, in_clk_n, out_clk, out_clk_n, read_port_select_n, write_port_select_n,
    input addr, wr_data, byte_write_select_n,
    output rd_data, rd_data_oe
  );
  modport ctrl (
    output in_clk, in_clk_n, out_clk, out_clk_n, read_port_select_n, write_port_select_n,
    output addr, wr_data, byte_write_select_n,
    input rd_data, rd_data_oe
  );
endinterface

// file: bsp_link_monitor.sv
// Checker for the wires between controller end and device end
`timescale 1ns/10ps
module bsp_link_monitor
  import bsp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_clk,
  input wire logic in_clk_n,
  input wire logic out_clk,
  input wire logic out_clk_n,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire bsp_addr_t addr,
  input wire bsp_word_t wr_data,
  input wire bsp_bws_t byte_write_select_n,
  input wire bsp_word_t rd_data,
  input wire logic rd_data_oe
);
  // ****
  // Ages since read start and since output clock rise
  // ****
  logic [4:0] rd_age;
  logic [4:0] c_age;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_age <= 5'h1F;
    end else if ($rose(in_clk) && !read_port_select_n) begin
      rd_age <= 5'h00;
    end else if (rd_age != 5'h1F) begin
      rd_age <= rd_age + 5'h01;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      c_age <= 5'h1F;
    end else if ($rose(out_clk)) begin
      c_age <= 5'h00;
    end else if (c_age != 5'h1F) begin
      c_age <= c_age + 5'h01;
    end
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_sel_setup;
    $rose(in_clk) |-> $stable({read_port_select_n, write_port_select_n, addr, byte_write_select_n});
  endproperty
  a_sel_setup: assert property (p_sel_setup) else $error("selects moved at input clock rise");
  property p_din_setup;
    $rose(in_clk_n) |-> $stable(addr) && $stable(wr_data) && $stable(byte_write_select_n);
  endproperty
  a_din_setup: assert property (p_din_setup) else $error("write half moved at second clock");
  property p_clk_pair;
    in_clk == !in_clk_n && out_clk == in_clk && out_clk_n == in_clk_n;
  endproperty
  a_clk_pair: assert property (p_clk_pair) else $error("clock pairs skewed");
  property p_half_k;
    $rose(in_clk) |-> in_clk [*3];
  endproperty
  a_half_k: assert property (p_half_k) else $error("input clock half too short");
  property p_rd_launch;
    $rose(in_clk) && !read_port_select_n |-> ##[10:12] rd_data_oe;
  endproperty
  a_rd_launch: assert property (p_rd_launch) else $error("read gave no data");
  property p_oe_cause;
    $rose(rd_data_oe) |-> rd_age inside {[9:11]};
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("data driven without read");
  property p_oe_release;
    $fell(rd_data_oe) |-> c_age inside {[1:3]};
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("outputs released off clock");
  property p_word_hold;
    $rose(rd_data_oe) |=> $stable(rd_data) [*3];
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("first word not held");
  property p_oe_span;
    $rose(rd_data_oe) |-> rd_data_oe [*8];
  endproperty
  a_oe_span: assert property (p_oe_span) else $error("burst cut short");
endmodule

// file: bsp_pair_buf.sv
// Two-entry valid/ready buffer for returned read bursts
`timescale 1ns/10ps
`include "bsp_consts.svh"
module bsp_pair_buf
  import bsp_pkg::*;
#(
  parameter int W = 2 * `BSP_WORD_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  logic [W-1:0] head;
  logic [W-1:0] tail;
  logic head_v;
  logic tail_v;
  logic push;
  logic pop;

  assign push = in_valid_i & ~tail_v;
  assign pop = head_v & out_ready_i;
  assign in_ready_o = ~tail_v;
  assign out_valid_o = head_v;
  assign out_data_o = head;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      head <= '0;
      tail <= '0;
      head_v <= 1'b0;
      tail_v <= 1'b0;
    end else if (pop) begin
      if (tail_v) begin
        head <= tail;
        if (push) begin
          tail <= in_data_i;
        end else begin
          tail_v <= 1'b0;
        end
      end else if (push) begin
        head <= in_data_i;
      end else begin
        head_v <= 1'b0;
      end
    end else if (push) begin
      if (!head_v) begin
        head <= in_data_i;
        head_v <= 1'b1;
      end else begin
        tail <= in_data_i;
        tail_v <= 1'b1;
      end
    end
  end
endmodule

// file: bsp_pkg.sv
// Types shared by both ends of the port link
`include "bsp_consts.svh"
package bsp_pkg;
  typedef logic [`BSP_ADDR_W-1:0] bsp_addr_t;
  typedef logic [`BSP_WORD_W-1:0] bsp_word_t;
  typedef logic [`BSP_LANES-1:0] bsp_bws_t;
  typedef struct packed {
    bsp_word_t hi;
    bsp_word_t lo;
  } bsp_burst_s;
  typedef enum {BSP_RD_IDLE, BSP_RD_WAIT} bsp_rd_e;
endpackage

// file: burst2_ddr_sram_ports_tb_top.sv
// Self-checking bench for both ends of the port link
`timescale 1ns/10ps
module burst2_ddr_sram_ports_tb_top;
  import bsp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rd_req_i = 1'b0;
  bsp_addr_t rd_addr_i = 19'h00000;
  logic wr_req_i = 1'b0;
  bsp_addr_t wr_addr_i = 19'h00000;
  logic [35:0] wr_data_i = 36'h000000000;
  logic [3:0] wr_bws_n_i = 4'hF;
  logic rd_ready_i = 1'b1;
  logic rd_ack_o, wr_ack_o, rd_valid_o, single_clock, imp_cal;
  logic [35:0] rd_data_o;
  logic [35:0] sc_data;
  logic [35:0] rd_exp;
  logic sc_valid;
  logic sc_strap;
  int num_errors = 0;
  int checked = 0;
  int seed = 32'h550768EE;
  int cyc = 0;
  int rdy_mode = 1;
  int last_cal = 0;
  int n_cal = 0;
  logic [35:0] mem [bsp_addr_t];
  bsp_addr_t rq [$];
  bsp_link_if link ();
  bsp_ctrl_end #(.SINGLE_CLOCK(1'b0)) bsp_ctrl_end_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i), .rd_ack_o(rd_ack_o), .wr_req_i(wr_req_i),
    .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .wr_bws_n_i(wr_bws_n_i), .wr_ack_o(wr_ack_o),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .rd_ready_i(rd_ready_i));
  bsp_dev_end bsp_dev_end_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link), .single_clock_o(single_clock),
    .impedance_cal_o(imp_cal));
  bsp_link_monitor bsp_link_monitor_inst (.clk_i(clk_i), .rst_i(rst_i), .in_clk(link.in_clk),
    .in_clk_n(link.in_clk_n), .out_clk(link.out_clk), .out_clk_n(link.out_clk_n),
    .read_port_select_n(link.read_port_select_n), .write_port_select_n(link.write_port_select_n),
    .addr(link.addr), .wr_data(link.wr_data), .byte_write_select_n(link.byte_write_select_n),
    .rd_data(link.rd_data), .rd_data_oe(link.rd_data_oe));
  // Single-clock pair fed the same requests
  bsp_link_if link_sc ();
  bsp_ctrl_end #(.SINGLE_CLOCK(1'b1)) bsp_ctrl_end_sc_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link_sc),
    .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i), .rd_ack_o(), .wr_req_i(wr_req_i),
    .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .wr_bws_n_i(wr_bws_n_i), .wr_ack_o(),
    .rd_valid_o(sc_valid), .rd_data_o(sc_data), .rd_ready_i(rd_ready_i));
  bsp_dev_end bsp_dev_end_sc_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link_sc), .single_clock_o(sc_strap),
    .impedance_cal_o());
  // ****
  // Clock, ready pattern, timeout, result watch
  // ****
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    #1;
    rd_ready_i = (rdy_mode == 2) ? 1'($random(seed)) : (rdy_mode == 1);
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      wrap_up();
    end
  end
  always @(negedge clk_i) begin
    if (!rst_i && rd_valid_o === 1'b1 && rd_ready_i === 1'b1) begin
      rd_exp = mem[rq.pop_front()];
      chk("rd_data_o", rd_data_o, rd_exp);
      chk("sc_valid", {35'h0, sc_valid}, 36'h1);
      chk("sc_data", sc_data, rd_exp);
    end
    if (imp_cal === 1'b1) begin
      if (n_cal > 0) begin
        chk("cal_gap", 36'(cyc - last_cal), 36'h2000);
      end
      last_cal = cyc;
      n_cal++;
    end
  end
  // ****
  // Tasks
  // ****
  task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask
  task automatic do_write(input bsp_addr_t a, input logic [35:0] d, input logic [3:0] b);
    int n;
    n = 0;
    wr_addr_i = a;
    wr_data_i = d;
    wr_bws_n_i = b;
    wr_req_i = 1'b1;
    while (wr_ack_o !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    chk("wr_ack_o", {35'h0, wr_ack_o}, 36'h1);
    for (int l = 0; l < 4; l++) begin
      if (!b[l]) begin
        mem[a][9*l +: 9] = d[9*l +: 9];
      end
    end
    wr_req_i = 1'b0;
    tick();
  endtask
  task automatic do_read(input bsp_addr_t a, input bit w);
    int n;
    n = 0;
    rd_addr_i = a;
    rd_req_i = 1'b1;
    while (rd_ack_o !== 1'b1 && n < 80) begin
      tick();
      n++;
    end
    chk("rd_ack_o", {35'h0, rd_ack_o}, 36'h1);
    rq.push_back(a);
    rd_req_i = 1'b0;
    tick();
    n = 0;
    while (w && rq.size() != 0 && n < 300) begin
      tick();
      n++;
    end
    if (w) begin
      chk("rd_wait", 36'(rq.size()), 36'h0);
    end
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    bsp_addr_t a;
    bsp_addr_t wa [6];
    logic [3:0] tab [5];
    int acks;
    tab = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hF};
    repeat (16) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    chk("rd_data_oe", {35'h0, link.rd_data_oe}, 36'h0);
    chk("selects", {34'h0, link.read_port_select_n, link.write_port_select_n}, 36'h3);
    chk("single_clock_o", {35'h0, single_clock}, 36'h0);
    a = 19'($random(seed));
    do_write(a, 36'({$random(seed), $random(seed)}), 4'h0);
    do_read(a, 1);
    foreach (tab[i]) begin
      do_write(a, 36'({$random(seed), $random(seed)}), tab[i]);
      do_read(a, 1);
    end
    for (int i = 0; i < 6; i++) begin
      wa[i] = 19'($random(seed));
      do_write(wa[i], 36'({$random(seed), $random(seed)}), 4'h0);
    end
    fork
      do_write(a, 36'({$random(seed), $random(seed)}), 4'h0);
      do_read(a, 1);
    join
    fork
      do_write(wa[5], 36'({$random(seed), $random(seed)}), 4'h5);
      do_read(wa[4], 1);
    join
    rdy_mode = 2;
    for (int i = 0; i < 6; i++) begin
      do_read(wa[i], 1);
    end
    rdy_mode = 0;
    tick();
    do_read(wa[0], 0);
    do_read(wa[1], 0);
    rd_addr_i = wa[2];
    rd_req_i = 1'b1;
    acks = 0;
    repeat (60) begin
      tick();
      acks += int'(rd_ack_o === 1'b1);
    end
    chk("held_ack", 36'(acks), 36'h0);
    chk("rd_valid_o", {35'h0, rd_valid_o}, 36'h1);
    rdy_mode = 1;
    do_read(wa[2], 1);
    while (n_cal < 2) begin
      tick();
    end
    chk("single_clock_o", {35'h0, single_clock}, 36'h0);
    chk("sc_strap", {35'h0, sc_strap}, 36'h1);
    wrap_up();
  end
endmodule
